// file: logic/giv_vectoring.sv
// module: grouped interrupt aggregator with jump table vector generation
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/10ps
module giv_vectoring
  import giv_pkg::*;
#(
  parameter int NUM_GROUPS = 4,
  parameter int SPACING    = SPACING_DEF
) (
  input  wire logic                            clk_sys,
  input  wire logic                            rst_n,
  input  wire giv_apb_req_t                    apbReq,
  output      giv_apb_rsp_t                    apbRsp,
  input  wire logic [NUM_GROUPS*SRC_PER_GROUP-1:0] srcIrq,
  output      giv_core_req_t                   coreReq,
  output      logic                            irqOut
);

  localparam int NSRC = SRC_PER_GROUP;

  typedef struct packed {
    logic [NUM_GROUPS-1:0][NSRC-1:0]             sts;
    logic [NUM_GROUPS-1:0][NSRC-1:0]             en;
    logic [NUM_GROUPS-1:0][NSRC-1:0][PRIO_W-1:0] prio;
    logic [NUM_GROUPS-1:0][VEC_W-1:0]            ctrl;
    logic [EVT_W-1:0]                            evtSts;
    logic [EVT_W-1:0]                            evtMask;
    giv_apb_rsp_t                                rsp;
    giv_core_req_t                               core;
    logic                                        irq;
  } giv_state_t;

  giv_state_t state_q;
  giv_state_t state_d;

  // byte enables to a bit mask
  function automatic logic [31:0] givByteMask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction

  // group window hit for an address
  function automatic logic givGrpHit(input logic [APB_AW-1:0] a);
    return (int'(a[APB_AW-1:5]) < NUM_GROUPS) && (a[4:2] <= REG_AGG_CTRL);
  endfunction

  // group index for an address
  function automatic int givGrpIdx(input logic [APB_AW-1:0] a);
    return int'(a[APB_AW-1:5]);
  endfunction

  // read mux for the register file
  function automatic logic [32:0] givRead(input giv_state_t s, input logic [APB_AW-1:0] a);
    logic [31:0] d;
    logic        err;
    int          g;
    d   = RST_ZERO;
    err = 1'b0;
    g   = givGrpIdx(a);
    if (givGrpHit(a)) begin
      unique case (a[4:2])
        REG_STATUS:  d[NSRC-1:0] = s.sts[g];
        REG_ENABLE:  d[NSRC-1:0] = s.en[g];
        REG_PRIO_LO: d = s.prio[g][PRIO_PER_WORD-1:0];
        REG_PRIO_HI: d[(NSRC-PRIO_PER_WORD)*PRIO_W-1:0] = s.prio[g][NSRC-1:PRIO_PER_WORD];
        default:     d[VEC_W-1:0] = s.ctrl[g];
      endcase
    end else if (a == OFS_EVT_STS) begin
      d[EVT_W-1:0] = s.evtSts;
    end else if (a == OFS_EVT_MASK) begin
      d[EVT_W-1:0] = s.evtMask;
    end else if (a == OFS_CUR_VEC) begin
      d[VEC_W-1:0] = s.core.vecAddr;
      d[CUR_LVL_LSB +: LEVEL_W] = s.core.level;
    end else begin
      err = 1'b1;
    end
    return {err, d};
  endfunction

  logic                            reqAccess;
  logic                            reqDone;
  logic                            wrDone;
  logic [31:0]                     wMask;
  logic [31:0]                     wBits;
  logic [NUM_GROUPS-1:0][NSRC-1:0] result;
  logic                            found;
  logic [PRIO_W-1:0]               bestPrio;
  logic [VEC_W-1:0]                bestVec;
  logic [VEC_W-1:0]                tblBase;
  logic [32:0]                     rdWord;
  logic [LEVEL_W-1:0]              newLevel;
  int                              wg;

  // apb phase decode: one wait state, write lands on the completing edge
  assign reqAccess = apbReq.psel & apbReq.penable;
  assign reqDone   = reqAccess & state_q.rsp.pready;
  assign wrDone    = reqDone & apbReq.pwrite & givGrpHit(apbReq.paddr);
  assign wMask     = givByteMask(apbReq.pstrb);
  assign wBits     = apbReq.pwdata & wMask;
  assign wg        = givGrpIdx(apbReq.paddr);

  // result bits per group, aggregated groups fold onto bit 0
  always_comb begin
    for (int g = 0; g < NUM_GROUPS; g++) begin
      if (state_q.ctrl[g][CTRL_MODE_BIT]) begin
        result[g] = state_q.sts[g] & state_q.en[g];
      end else begin
        result[g]    = '0;
        result[g][0] = |(state_q.sts[g] & state_q.en[g]);
      end
    end
  end

  // priority encoder over every group and result bit
  always_comb begin
    found    = 1'b0;
    bestPrio = '0;
    bestVec  = '0;
    tblBase  = '0;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      tblBase = {state_q.ctrl[g][VEC_W-1:1], 1'b0};
      for (int n = 0; n < NSRC; n++) begin
        // strictly greater keeps the lowest index on a tie
        if (result[g][n] && (!found || state_q.prio[g][n] > bestPrio)) begin
          found    = 1'b1;
          bestPrio = state_q.prio[g][n];
          bestVec  = VEC_W'(tblBase + VEC_W'(n * SPACING));
        end
      end
    end
    newLevel = found ? LEVEL_W'({1'b0, bestPrio} + 3'h1) : LVL_NONE;
  end

  assign rdWord = givRead(state_q, apbReq.paddr);

  // next-state: sources, register writes, core request, events, bus answer
  always_comb begin
    state_d = state_q;

    // apb answer: pready one cycle into the access phase
    state_d.rsp.pready  = reqAccess & ~state_q.rsp.pready;
    state_d.rsp.prdata  = RST_ZERO;
    state_d.rsp.pslverr = 1'b0;
    if (reqAccess && !state_q.rsp.pready) begin
      state_d.rsp.prdata  = apbReq.pwrite ? RST_ZERO : rdWord[31:0];
      state_d.rsp.pslverr = rdWord[32] ||
                            (apbReq.pwrite && apbReq.paddr == OFS_CUR_VEC);
    end

    // group register writes
    if (wrDone) begin
      unique case (apbReq.paddr[4:2])
        REG_STATUS:  state_d.sts[wg] = state_q.sts[wg] & ~wBits[NSRC-1:0];
        REG_ENABLE:  state_d.en[wg]  = (state_q.en[wg] & ~wMask[NSRC-1:0]) | wBits[NSRC-1:0];
        REG_PRIO_LO: state_d.prio[wg][PRIO_PER_WORD-1:0] =
                       (state_q.prio[wg][PRIO_PER_WORD-1:0] & ~wMask) | wBits;
        REG_PRIO_HI: state_d.prio[wg][NSRC-1:PRIO_PER_WORD] =
                       (state_q.prio[wg][NSRC-1:PRIO_PER_WORD] & ~wMask[29:0]) | wBits[29:0];
        default:     state_d.ctrl[wg] = (state_q.ctrl[wg] & ~wMask[VEC_W-1:0]) | wBits[VEC_W-1:0];
      endcase
    end

    // sources latch after the clear so a same-cycle event is kept
    for (int g = 0; g < NUM_GROUPS; g++) begin
      state_d.sts[g] = state_d.sts[g] | srcIrq[g*NSRC +: NSRC];
    end

    // block registers
    if (reqDone && apbReq.pwrite && apbReq.paddr == OFS_EVT_STS) begin
      state_d.evtSts = state_q.evtSts & ~wBits[EVT_W-1:0];
    end
    if (reqDone && apbReq.pwrite && apbReq.paddr == OFS_EVT_MASK) begin
      state_d.evtMask = (state_q.evtMask & ~wMask[EVT_W-1:0]) | wBits[EVT_W-1:0];
    end

    // vector and level to the core together
    state_d.core.vecAddr = found ? bestVec : '0;
    state_d.core.level   = newLevel;

    // events set after clear: new request, and a change to another vector while a request is pending
    if (state_q.core.level == LVL_NONE && newLevel != LVL_NONE) begin
      state_d.evtSts[EVT_NEW_BIT] = 1'b1;
    end
    if (state_q.core.level != LVL_NONE && found && bestVec != state_q.core.vecAddr) begin
      state_d.evtSts[EVT_CHG_BIT] = 1'b1;
    end
    state_d.irq = |(state_d.evtSts & state_d.evtMask);
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs straight from the state register
  assign apbRsp  = state_q.rsp;
  assign coreReq = state_q.core;
  assign irqOut  = state_q.irq;

endmodule

// file: logic/giv_pkg.sv
// package: constants and carrier types for the grouped interrupt vectoring block
// What this block does
// - each group selects aggregated or disaggregated operation on its own
// - aggregated group ORs all its enabled sources onto result bit 0
// - each result bit carries the priority of its own priority field
// - vector comes from the active result bit with highest priority
// - equal highest priority: lowest result bit index wins
// - a group has at most 31 sources, each its own table entry when disaggregated
// - group control register holds a 17-bit jump table offset
// - control bits 17:1 give table address, bit 0 selects the mode
// - vector of source n equals table base plus n times spacing (8)
// - each source has 2-bit priority; setting zero requests level 1
// - fired source delivers both vector address and requested priority level
package giv_pkg;

  localparam int          APB_AW        = 12;
  localparam int          SRC_PER_GROUP = 31;
  localparam int          PRIO_W        = 2;
  localparam int          LEVEL_W       = 3;
  localparam int          VEC_W         = 18;
  localparam int          SPACING_DEF   = 8;

  // per-group register window, stride and offsets
  localparam logic [11:0] GRP_STRIDE    = 12'h020;
  localparam logic [2:0]  REG_STATUS    = 3'h0;   // sticky source bits, write one to clear
  localparam logic [2:0]  REG_ENABLE    = 3'h1;
  localparam logic [2:0]  REG_PRIO_LO   = 3'h2;   // sources 0..15, 2 bits each
  localparam logic [2:0]  REG_PRIO_HI   = 3'h3;   // sources 16..30
  localparam logic [2:0]  REG_AGG_CTRL  = 3'h4;

  // block-level registers
  localparam logic [11:0] OFS_EVT_STS   = 12'h200;
  localparam logic [11:0] OFS_EVT_MASK  = 12'h204;
  localparam logic [11:0] OFS_CUR_VEC   = 12'h208;

  // field positions
  localparam int          CTRL_MODE_BIT = 0;
  localparam int          EVT_NEW_BIT   = 0;
  localparam int          EVT_CHG_BIT   = 1;
  localparam int          EVT_W         = 2;
  localparam int          CUR_LVL_LSB   = 24;
  localparam int          PRIO_PER_WORD = 16;

  // reset values
  localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
  localparam logic [VEC_W-1:0] CTRL_RST = 18'h00000;
  localparam logic [LEVEL_W-1:0] LVL_NONE = 3'h0;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
  } giv_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } giv_apb_rsp_t;

  typedef struct packed {
    logic [VEC_W-1:0]   vecAddr;
    logic [LEVEL_W-1:0] level;
  } giv_core_req_t;

endpackage

// file: verification/giv_vectoring_checker.sv
// checker: port-level properties of the vectoring block
`timescale 1ns/10ps
module giv_vectoring_checker
  import giv_pkg::*;
#(
  parameter int NUM_GROUPS = 4,
  parameter int SPACING    = SPACING_DEF
) (
  input wire logic                                clk_sys,
  input wire logic                                rst_n,
  input wire giv_apb_req_t                        apbReq,
  input wire giv_apb_rsp_t                        apbRsp,
  input wire logic [NUM_GROUPS*SRC_PER_GROUP-1:0] srcIrq,
  input wire giv_core_req_t                       coreReq,
  input wire logic                                irqOut
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_level_in_range: assert property (coreReq.level <= 3'h4) else $error("level above four");
  a_idle_vector: assert property (coreReq.level == 3'h0 |-> coreReq.vecAddr == '0)
    else $error("vector without request");
  a_vector_even: assert property (coreReq.vecAddr[0] == 1'b0) else $error("odd vector address");
  a_reset_quiet: assert property ($rose(rst_n) |-> coreReq.level == 3'h0 && !irqOut)
    else $error("request right after reset");
  a_no_spont_req: assert property ($past(coreReq.level) == 3'h0 && $past(srcIrq) == '0 &&
    $past(srcIrq, 2) == '0 && !$past(apbReq.psel) && !$past(apbReq.psel, 2) |-> coreReq.level == 3'h0)
    else $error("request without a cause");
  a_ready_pulse: assert property (apbRsp.pready |=> !apbRsp.pready) else $error("ready held too long");
  a_one_wait: assert property (apbReq.psel && apbReq.penable && !apbRsp.pready |=> apbRsp.pready)
    else $error("ready late");
  a_quiet_data: assert property (!apbRsp.pready |-> apbRsp.prdata == 32'h0 && !apbRsp.pslverr)
    else $error("read data outside ready");
  c_top_level: cover property (coreReq.level == 3'h4);
  c_bus_error: cover property (apbRsp.pready && apbRsp.pslverr);
  c_irq_rise: cover property ($rose(irqOut));
endmodule
bind giv_vectoring giv_vectoring_checker #(.NUM_GROUPS(NUM_GROUPS), .SPACING(SPACING)) i_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp), .srcIrq(srcIrq),
  .coreReq(coreReq), .irqOut(irqOut));

// file: verification/giv_core_model.sv
// far-side model: processor core taking vector requests
`timescale 1ns/10ps
module giv_core_model
  import giv_pkg::*;
#(
  parameter logic [31:0] EXC_BASE = 32'hbfd0_0000
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire giv_core_req_t coreReq,
  output      logic [31:0]   jumpAddr
);
  // latch the jump target of each pending request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      jumpAddr <= 32'h0000_0000;
    end else if (coreReq.level != 3'h0) begin
      jumpAddr <= EXC_BASE + {14'h0000, coreReq.vecAddr};
    end
  end
endmodule

// file: verification/grouped_interrupt_vectoring_tb_top.sv
// testbench: register access, vector selection and interrupt scenarios
`timescale 1ns/10ps
module grouped_interrupt_vectoring_tb_top;
  import giv_pkg::*;
  logic          clk_sys = 1'b0;
  logic          rst_n = 1'b0;
  giv_apb_req_t  req = '0;
  giv_apb_rsp_t  rsp;
  logic [123:0]  srcIrq = '0;
  giv_core_req_t coreReq;
  logic          irqOut;
  logic [31:0]   jumpAddr;
  logic [31:0]   rd;
  logic          er;
  int            err_count = 0;
  int            total_checks = 0;
  int            cyc = 0;
  always #20 clk_sys = ~clk_sys;
  giv_vectoring #(.NUM_GROUPS(4), .SPACING(8)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .apbReq(req),
    .apbRsp(rsp), .srcIrq(srcIrq), .coreReq(coreReq), .irqOut(irqOut));
  giv_core_model i_core (.clk_sys(clk_sys), .rst_n(rst_n), .coreReq(coreReq), .jumpAddr(jumpAddr));
  // one bus transfer, held until ready is seen at a rising edge; answer taken at that edge
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge clk_sys);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: data, pstrb: 4'hf};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic drive(input int idx, input logic val);
    @(posedge clk_sys);
    srcIrq[idx] <= val;
    idle(3);
  endtask
  // drop all sources, clear one group, expect no request
  task automatic quiet(input logic [11:0] base);
    @(posedge clk_sys);
    srcIrq <= '0;
    apb(1'b1, base, 32'h7fff_ffff);
    idle(2);
    chk("no request", {29'h0, coreReq.level}, 32'h0);
  endtask
  task automatic t_reset;
    apb(1'b0, 12'h010, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    apb(1'b0, 12'h3fc, 32'h0);
    chk("unmapped error", {31'h0, er}, 32'h1);
    apb(1'b1, 12'h208, 32'h0);
    chk("read-only error", {31'h0, er}, 32'h1);
    $display("done reset");
  endtask
  task automatic t_disagg;
    apb(1'b1, 12'h010, 32'h0000_0501);
    apb(1'b1, 12'h004, 32'h7fff_ffff);
    drive(29, 1'b1);
    chk("jump 29", jumpAddr, 32'hbfd0_05e8);
    chk("level 29", {29'h0, coreReq.level}, 32'h1);
    quiet(12'h000);
    drive(2, 1'b1);
    chk("jump 2", jumpAddr, 32'hbfd0_0510);
    quiet(12'h000);
    $display("done disaggregated");
  endtask
  task automatic t_prio;
    apb(1'b1, 12'h008, 32'h0000_0c30);
    drive(29, 1'b1);
    drive(5, 1'b1);
    chk("prio winner", jumpAddr, 32'hbfd0_0528);
    chk("prio level", {29'h0, coreReq.level}, 32'h4);
    drive(2, 1'b1);
    chk("tie winner", jumpAddr, 32'hbfd0_0510);
    quiet(12'h000);
    $display("done priority");
  endtask
  task automatic t_agg;
    apb(1'b1, 12'h030, 32'h0000_0600);
    apb(1'b1, 12'h024, 32'h0000_0080);
    apb(1'b1, 12'h028, 32'h0000_0001);
    apb(1'b1, 12'h200, 32'h0000_0003);
    apb(1'b1, 12'h204, 32'h0000_0001);
    drive(38, 1'b1);
    chk("agg jump", jumpAddr, 32'hbfd0_0600);
    chk("agg level", {29'h0, coreReq.level}, 32'h2);
    apb(1'b0, 12'h208, 32'h0);
    chk("current vector", rd, 32'h0200_0600);
    idle(2);
    chk("irq raised", {31'h0, irqOut}, 32'h1);
    apb(1'b1, 12'h204, 32'h0);
    idle(2);
    chk("irq masked", {31'h0, irqOut}, 32'h0);
    apb(1'b1, 12'h204, 32'h0000_0001);
    apb(1'b1, 12'h200, 32'h0000_0003);
    idle(2);
    chk("irq cleared", {31'h0, irqOut}, 32'h0);
    quiet(12'h020);
    $display("done aggregated");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // cut a hung run short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      give_verdict;
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset;
    t_disagg;
    t_prio;
    t_agg;
    give_verdict;
  end
endmodule
